// ---- src/bpu_pkg.sv ----
// package for the backplane utility-signal block on the processor board
// assumes one 20 MHz system clock and an asynchronous active-high reset
package bpu_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_HZ          = 20_000_000;  // system clock rate
  localparam int unsigned POWERUP_HOLD_MS = 120;         // reset hold after supply good
  localparam int unsigned POWERDN_MAX_MS  = 15;          // latest reassert after supply drop
  // least time truncates like the longest; exact at 20 MHz
  localparam int unsigned POWERUP_CYCLES  =
    (POWERUP_HOLD_MS * (CLK_HZ / 1000));
  // longest time rounds down; reassertion here takes three cycles
  localparam int unsigned POWERDN_CYCLES  =
    (POWERDN_MAX_MS * (CLK_HZ / 1000));
  localparam int unsigned CNT_W           = 22;          // holds 2_400_000

  // ==========================================================================
  // cycle-type codes
  localparam logic [2:0] CYCLE_TYPE_INTERRUPT_ACKNOWLEDGE_LINE  = 3'h7;        // interrupt acknowledge

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic       oe;          // high while this board drives the lines
    logic [2:0] value;       // driven level
  } bpu_cycle_type_s;

  typedef struct packed {
    logic reset_o;           // open-drain reset drive (1 = pull low)
    logic stop_o;            // stop-request drive
  } bpu_reset_drive_s;

  // power sequencer states
  typedef enum logic [1:0] {
    BPU_ST_OFF  = 2'b00,     // supply not good, reset held
    BPU_ST_HOLD = 2'b01,     // supply good, counting out hold time
    BPU_ST_RUN  = 2'b10      // reset released
  } bpu_pwr_e;

endpackage : bpu_pkg

// ---- src/bpu_sync.sv ----
// two-flop synchroniser, one per bit
// assumes the inputs come from pins outside the clock domain
`timescale 1ns/1ps
module bpu_sync
  import bpu_pkg::*;
#(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] d,
  output      logic [WIDTH-1:0] q
);

  // ==========================================================================
  // stages
  logic [WIDTH-1:0] stage1;   // read only by stage two
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_q;

  // next values
  always_comb begin
    next_stage1 = d;
    next_q      = stage1;
  end

  // registers
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      q      <= '0;
    end else begin
      stage1 <= next_stage1;
      q      <= next_q;
    end
  end

endmodule : bpu_sync

// ---- src/bpu_top.sv ----
// processor-board utility-signal logic: bus reset sequencing, reset routing,
// and the buffered cycle-type driver with its address strobe
// assumes pins are external (synchronised here) and cpu signals share clk_sys
//
// Contract
// - hold bus reset 120 ms after supply good
// - reassert bus reset within 15 ms of drop
// - processor reset instruction drives bus reset
// - foreign reset alone spares processor board
// - float cycle-type lines on handover or acknowledge
// - strobe released to pull-up during acknowledge
`timescale 1ns/1ps
module bpu_top
  import bpu_pkg::*;
#(
  parameter int unsigned POWERUP_CNT = POWERUP_CYCLES,  // shorten in simulation
  parameter int unsigned POWERDN_CNT = POWERDN_CYCLES
) (
  // clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // supply monitors (asynchronous pins)
  input  wire logic       supply_good,        // main supply above valid threshold
  input  wire logic       supply_low,         // main supply sagging toward fail
  // processor side (same clock)
  input  wire logic       cpu_reset_instr,    // reset instruction in progress
  input  wire logic       cpu_addr_strobe,    // cpu strobe, active high
  input  wire logic [2:0] cpu_cycle_type,     // cpu cycle-type code
  input  wire logic       bus_granted,        // bus handed to another master
  // backplane reset and stop (open drain, asynchronous inputs)
  input  wire logic       bus_reset_n_i,      // wire level of reset
  output      logic       bus_reset_n_o,      // always 0 when enabled
  output      logic       bus_reset_n_oe,     // high while pulling low
  input  wire logic       bus_stop_n_i,       // wire level of stop-request
  // backplane cycle-type and strobe (three-state)
  output      logic [2:0] buffered_cycle_type,
  output      logic       buffered_cycle_type_oe,
  output      logic       bus_address_strobe_n,
  output      logic       bus_address_strobe_oe,
  // reset to this board's processor and logic
  output      logic       board_reset
);

  // ==========================================================================
  // pin synchronisers
  logic [3:0] pins_sync;
  bpu_sync #(.WIDTH(4)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .d       ({supply_good, supply_low, bus_reset_n_i, bus_stop_n_i}),
    .q       (pins_sync)
  );
  logic good_s, low_s, rst_line_n_s, stop_n_s;  // synchronised pin levels
  assign good_s       = pins_sync[3];
  assign low_s        = pins_sync[2];
  assign rst_line_n_s = pins_sync[1];
  assign stop_n_s     = pins_sync[0];

  // ==========================================================================
  // power sequencer
  bpu_pwr_e         state, next_state;
  logic [CNT_W-1:0] hold_cnt, next_hold_cnt;  // time since supply good
  logic             pwr_reset;                // sequencer wants reset
  logic             next_pwr_reset;

  // any supply fault drops straight back to off; reset follows next edge
  always_comb begin
    next_state     = state;
    next_hold_cnt  = hold_cnt;
    unique case (state)
      BPU_ST_OFF: begin
        next_hold_cnt = '0;
        if (good_s && !low_s) begin
          next_state = BPU_ST_HOLD;
        end
      end
      BPU_ST_HOLD: begin
        if (!good_s || low_s) begin
          next_state = BPU_ST_OFF;
        end else if (hold_cnt >= CNT_W'(POWERUP_CNT - 1)) begin
          next_state = BPU_ST_RUN;
        end else begin
          next_hold_cnt = hold_cnt + CNT_W'(1);
        end
      end
      BPU_ST_RUN: begin
        if (!good_s || low_s) begin
          next_state = BPU_ST_OFF;
        end
      end
      default: next_state = BPU_ST_OFF;
    endcase
    next_pwr_reset = (next_state != BPU_ST_RUN);
  end

  // sequencer registers; reset held from power-on
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state     <= BPU_ST_OFF;
      hold_cnt  <= '0;
      pwr_reset <= 1'b1;
    end else begin
      state     <= next_state;
      hold_cnt  <= next_hold_cnt;
      pwr_reset <= next_pwr_reset;
    end
  end

  // ==========================================================================
  // reset drive and routing
  logic drive_reset, next_drive_reset;
  logic next_board_reset;
  logic foreign_reset;   // reset seen on wire while we are not driving it

  always_comb begin
    // processor instruction or power sequencer pulls the line
    next_drive_reset = next_pwr_reset || cpu_reset_instr;
    foreign_reset    = !rst_line_n_s && !drive_reset;
    // a foreign reset alone leaves this board running
    next_board_reset = next_pwr_reset || (foreign_reset && !stop_n_s);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      drive_reset <= 1'b1;
      board_reset <= 1'b1;
    end else begin
      drive_reset <= next_drive_reset;
      board_reset <= next_board_reset;
    end
  end

  assign bus_reset_n_o  = 1'b0;
  assign bus_reset_n_oe = drive_reset;

  // ==========================================================================
  // cycle-type buffer; strobe shares it
  logic       next_buf_oe;
  logic [2:0] next_cycle_type;
  logic       next_strobe_n;

  // buffer off on handover and on acknowledge code; strobe left to pull-up
  always_comb begin
    next_buf_oe     = !bus_granted && (cpu_cycle_type != CYCLE_TYPE_INTERRUPT_ACKNOWLEDGE_LINE);
    next_cycle_type = next_buf_oe ? cpu_cycle_type : 3'h0;
    next_strobe_n   = next_buf_oe ? !cpu_addr_strobe : 1'b1;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      buffered_cycle_type_oe <= 1'b0;
      buffered_cycle_type    <= 3'h0;
      bus_address_strobe_n   <= 1'b1;
    end else begin
      buffered_cycle_type_oe <= next_buf_oe;
      buffered_cycle_type    <= next_cycle_type;
      bus_address_strobe_n   <= next_strobe_n;
    end
  end

  assign bus_address_strobe_oe = buffered_cycle_type_oe;

  // ==========================================================================
  // checks
  // drive register is high in every cycle the sequencer is outside run; a reset instruction also sets it in run
  a_reset_held_run: assert property (@(posedge clk_sys) disable iff (rst)
    (state != BPU_ST_RUN) |-> bus_reset_n_oe)
    else $error("bus reset not held before run");
  a_powerdn_reassert: assert property (@(posedge clk_sys) disable iff (rst)
    (low_s && state == BPU_ST_RUN) |-> ##[1:2] bus_reset_n_oe)
    else $error("bus reset late after supply drop");
  a_cpu_reset_drive: assert property (@(posedge clk_sys) disable iff (rst)
    cpu_reset_instr |=> bus_reset_n_oe)
    else $error("reset instruction did not drive bus");
  // staying in run with no stop request must leave the board running
  a_foreign_spared: assert property (@(posedge clk_sys) disable iff (rst)
    (state == BPU_ST_RUN && next_state == BPU_ST_RUN && stop_n_s) |=> !board_reset)
    else $error("board reset without stop request");
  a_interrupt_acknowledge_line_float: assert property (@(posedge clk_sys) disable iff (rst)
    (cpu_cycle_type == CYCLE_TYPE_INTERRUPT_ACKNOWLEDGE_LINE || bus_granted)
      |=> !buffered_cycle_type_oe)
    else $error("cycle-type driven during acknowledge or handover");
  // acknowledge code must hand the strobe to its pull-up next cycle
  a_strobe_release: assert property (@(posedge clk_sys) disable iff (rst)
    (cpu_cycle_type == CYCLE_TYPE_INTERRUPT_ACKNOWLEDGE_LINE) |=> bus_address_strobe_n && !bus_address_strobe_oe)
    else $error("strobe driven while buffer off");

endmodule : bpu_top

// ---- verification/bpu_slave_model.sv ----
// model of a backplane slave card facing the processor-board utility logic
// assumes the bench commands its reset and stop drives
`timescale 1ns/1ps
module bpu_slave_model
  import bpu_pkg::*;
(
  // clock
  input  wire logic       clk_sys,
  // bench commands
  input  wire logic       drv_reset,   // slave pulls reset low
  input  wire logic       drv_stop,    // slave pulls stop-request low
  input  wire logic       allow_both,  // scenario wants the forbidden pair
  // host board drives
  input  wire logic       host_rst_o,
  input  wire logic       host_rst_oe,
  input  wire logic [2:0] host_ct,
  input  wire logic       host_ct_oe,
  input  wire logic       host_as_n,
  input  wire logic       host_as_oe,
  // resolved wire levels
  output      logic       bus_reset_n,
  output      logic       bus_stop_n,
  output      logic [2:0] ct_level,
  output      logic       strobe_level,
  output      logic [2:0] seen_type    // last type taken under strobe
);
  // ==========================================================================
  // wires
  logic [2:0] last_ct;  // floating lines show the inverse of this
  logic [1:0] rst_sync; // slave-side synchroniser
  // open-drain reset with pull-up
  assign bus_reset_n  = ~((host_rst_oe & ~host_rst_o) | drv_reset);
  // stop only joins reset when the scenario asks for it
  assign bus_stop_n   = ~(drv_stop & (~drv_reset | allow_both));
  // no pull-ups on cycle-type lines, so no stable value when released
  assign ct_level     = host_ct_oe ? host_ct : ~last_ct;
  assign strobe_level = host_as_oe ? host_as_n : 1'b1;
  // ==========================================================================
  // sampling
  always_ff @(posedge clk_sys) begin
    last_ct  <= ct_level;
    rst_sync <= {rst_sync[0], bus_reset_n};
    // type trusted only under strobe, never on acknowledge
    if (!strobe_level && rst_sync[1]) begin
      seen_type <= ct_level;
    end
  end
endmodule : bpu_slave_model

// ---- verification/tb_top.sv ----
// self-checking bench for the utility-signal block
// assumes the slave model stands on the backplane side
`timescale 1ns/1ps
module tb_top;
  import bpu_pkg::*;
  localparam int unsigned PU = 20;  // shortened hold count
  // ==========================================================================
  // signals
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic sg = 1'b0, sl = 1'b0, rin = 1'b0, str = 1'b0, gr = 1'b0;
  logic [2:0] ct = 3'h0;
  logic dr = 1'b0, ds = 1'b0, ab = 1'b0;
  logic rn_i, rn_o, rn_oe, st_i, bct_oe, as_n, as_oe, brst, sl_as;
  logic [2:0] bct, ct_l, seen;
  int err_count = 0;
  int comparisons = 0;
  always #25 clk_sys = ~clk_sys;
  // ==========================================================================
  // instances
  bpu_top #(.POWERUP_CNT(PU), .POWERDN_CNT(5)) u_bpu_top (.clk_sys(clk_sys),
    .rst(rst), .supply_good(sg), .supply_low(sl), .cpu_reset_instr(rin),
    .cpu_addr_strobe(str), .cpu_cycle_type(ct), .bus_granted(gr),
    .bus_reset_n_i(rn_i), .bus_reset_n_o(rn_o), .bus_reset_n_oe(rn_oe),
    .bus_stop_n_i(st_i), .buffered_cycle_type(bct),
    .buffered_cycle_type_oe(bct_oe), .bus_address_strobe_n(as_n),
    .bus_address_strobe_oe(as_oe), .board_reset(brst));
  bpu_slave_model u_bpu_slave_model (.clk_sys(clk_sys), .drv_reset(dr),
    .drv_stop(ds), .allow_both(ab), .host_rst_o(rn_o), .host_rst_oe(rn_oe),
    .host_ct(bct), .host_ct_oe(bct_oe), .host_as_n(as_n), .host_as_oe(as_oe),
    .bus_reset_n(rn_i), .bus_stop_n(st_i), .ct_level(ct_l),
    .strobe_level(sl_as), .seen_type(seen));
  // ==========================================================================
  // helpers
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #5;
  endtask : step
  task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string m);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task automatic finish_test;
    if (err_count == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test
  // ==========================================================================
  // scenarios
  task automatic t_powerup;  // count cycles from supply good to release
    int k;
    k = 0;
    sg = 1'b1;
    sl = 1'b0;
    while (rn_oe !== 1'b0 && k < 60) begin
      step(1);
      k++;
    end
    chk({3'h0, k >= PU && k <= PU + 8}, 4'h1, "hold time");
    step(1);
    chk({3'h0, brst}, 4'h0, "board still reset");
  endtask : t_powerup
  task automatic t_powerdown;
    sl = 1'b1;
    step(5);
    chk({2'h0, rn_oe, brst}, 4'h3, "no reassert");
    t_powerup();
    sg = 1'b0;
    step(5);
    chk({2'h0, rn_oe, brst}, 4'h3, "no reassert on supply loss");
    t_powerup();
  endtask : t_powerdown
  task automatic t_reset_instr;
    rin = 1'b1;
    step(2);
    chk({2'h0, rn_oe, brst}, 4'h2, "reset instr");
    chk({3'h0, rn_o}, 4'h0, "reset drive level");
    rin = 1'b0;
    step(2);
    chk({2'h0, rn_oe, brst}, 4'h0, "reset instr end");
  endtask : t_reset_instr
  task automatic t_cycle_type;  // codes 0..7, then handover
    logic e;
    for (int i = 0; i < 9; i++) begin
      ct = i[2:0];
      str = 1'b1;
      gr = (i == 8);
      e = (i < 7);
      step(1);
      chk({bct_oe, as_oe, sl_as, 1'b0}, {e, e, ~e, 1'b0}, "buffer enable");
      if (e) chk({1'b0, bct}, {1'b0, i[2:0]}, "type value");
    end
    str = 1'b0;
    gr = 1'b0;
    step(1);
    chk({1'b0, seen}, 4'h6, "strobe qualify");
    chk({3'h0, sl_as}, 4'h1, "strobe idle");
  endtask : t_cycle_type
  task automatic t_foreign;
    dr = 1'b1;
    step(8);
    chk({3'h0, brst}, 4'h0, "slave reset hit board");
    ds = 1'b1;
    ab = 1'b1;
    step(5);
    chk({3'h0, brst}, 4'h1, "reset with stop");
    dr = 1'b0;
    ds = 1'b0;
  endtask : t_foreign
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (16) @(posedge clk_sys);
    #5 rst = 1'b0;
    step(1);
    chk({3'h0, rn_oe}, 4'h1, "reset held");
    t_powerup();
    t_powerdown();
    t_reset_instr();
    t_cycle_type();
    t_foreign();
    finish_test();
  end
  initial begin
    #1_000_000;
    err_count++;
    finish_test();
  end
endmodule : tb_top
